// >>> src/qmtc_pkg.sv
package qmtc_pkg;

    // ---------------------------------------------------------------
    // register placement and field layout
    // ---------------------------------------------------------------
    localparam logic [3:0]  QMTC_WORD_BYTE_OFS = 4'h8;  // bytes 11:8
    localparam int          QMTC_BYTES         = 4;
    localparam int          QMTC_PRIV_BIT      = 29;
    localparam int          QMTC_IDEN_BIT      = 28;
    localparam int          QMTC_ID_HI         = 27;
    localparam int          QMTC_ID_LO         = 8;
    localparam int          QMTC_ID_W          = 20;
    localparam int          QMTC_PRIO_HI       = 7;
    localparam int          QMTC_PRIO_LO       = 4;
    localparam int          QMTC_PRIO_W        = 4;
    localparam int          QMTC_PRS_DIS_BIT   = 3;
    localparam int          QMTC_ATS_DIS_BIT   = 2;
    localparam int          QMTC_FBE_BIT       = 1;
    localparam int          QMTC_MODE_BIT      = 0;
    localparam logic [31:0] QMTC_WORD_RESET    = 32'h0000_0000;
    // bits 31:30 are reserved and read as zero
    localparam logic [31:0] QMTC_WORD_MASK     = 32'h3fff_ffff;

    // queue mode encodings
    localparam logic        QMTC_MODE_SHARED    = 1'b0;
    localparam logic        QMTC_MODE_DEDICATED = 1'b1;

    // ---------------------------------------------------------------
    // enable-time consistency error bits
    // ---------------------------------------------------------------
    localparam int          QMTC_ERR_W         = 6;
    localparam int          QMTC_ERR_PRIV      = 0;
    localparam int          QMTC_ERR_IDEN_CAP  = 1;
    localparam int          QMTC_ERR_SHR_IDEN  = 2;
    localparam int          QMTC_ERR_PRIO_ZERO = 3;
    localparam int          QMTC_ERR_PRS_FBE   = 4;
    localparam int          QMTC_ERR_PRS_LOG   = 5;

    typedef enum logic {
        QMTC_ST_DISABLED,
        QMTC_ST_ENABLED
    } qmtc_state_e;

    // device capability and pcie enable bundle
    typedef struct packed {
        logic priority_support;
        logic prs_support;
        logic ats_support;
        logic fault_block_support;
        logic pasid_enable;
        logic priv_mode_enable;
        logic ats_enable;
        logic prs_enable;
        logic event_log_enable;
    } qmtc_caps_s;

    // per-descriptor attributes handed to the engine
    typedef struct packed {
        logic                 priv;
        logic [QMTC_ID_W-1:0] pasid;
        logic                 pasid_valid;
        logic                 use_ats;
        logic                 use_prs;
        logic                 block_on_fault;
    } qmtc_desc_s;

endpackage

// >>> src/qmtc_checker.sv
`timescale 1ns/1ps

// combinational consistency checks run when the queue is enabled
module qmtc_checker (
    // stored configuration word
    input  wire logic [31:0]                    cfg_word,
    // capability bundle
    input  wire qmtc_pkg::qmtc_caps_s           caps,
    // one bit per failed check
    output logic [qmtc_pkg::QMTC_ERR_W-1:0]     err
);
    import qmtc_pkg::*;

    logic ded;
    logic iden;

    assign ded  = (cfg_word[QMTC_MODE_BIT] == QMTC_MODE_DEDICATED);
    assign iden = cfg_word[QMTC_IDEN_BIT];

    // each term catches a setting that software was obliged to avoid
    always_comb begin
        err = '0;
        err[QMTC_ERR_PRIV]      = ded && iden && !caps.priv_mode_enable
                                  && cfg_word[QMTC_PRIV_BIT];
        err[QMTC_ERR_IDEN_CAP]  = iden && !caps.pasid_enable;
        err[QMTC_ERR_SHR_IDEN]  = !ded && !iden;
        err[QMTC_ERR_PRIO_ZERO] = caps.priority_support
            && (cfg_word[QMTC_PRIO_HI:QMTC_PRIO_LO] == '0);
        err[QMTC_ERR_PRS_FBE]   = cfg_word[QMTC_PRS_DIS_BIT]
                                  && cfg_word[QMTC_FBE_BIT];
        err[QMTC_ERR_PRS_LOG]   = cfg_word[QMTC_PRS_DIS_BIT]
                                  && !caps.event_log_enable;
    end

endmodule // qmtc_checker

// >>> src/qmtc_top.sv
// How it works
// - dedicated queue with identifier enabled stamps stored privilege.
// - descriptors carry identifier tag only while identifier enable is set.
// - 20-bit identifier used in dedicated mode with identifier enable set, ignored otherwise.
// - priority field honoured only when priority support is advertised.
// - page requests follow pcie enable unless page-request disable is set.
// - page-request disable forbids page requests; blocking enable clear.
// - page-request disable hardwired zero without support; needs event log.
// - translation-service disable overrides pcie enable for this queue.
// - translation-service disable reads zero without per-queue support.
// - fault-blocking off means faults stop and are reported.
// - fault-blocking on lets each descriptor flag pick fault handling.
// - fault-blocking enable reserved without support or page request enable.
// - bit 0 selects shared (0) or dedicated (1) mode.
// - configuration fields writable only while the queue is disabled.
// - writes to read-only fields are discarded.
// - consistency checks run when the queue is enabled.
`timescale 1ns/1ps

module qmtc_top (
    // clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // configuration word access
    input  wire logic                          cfg_wr_en,
    input  wire logic [qmtc_pkg::QMTC_BYTES-1:0] cfg_be,
    input  wire logic [31:0]                   cfg_wdata,
    output logic [31:0]                        cfg_rdata,
    // capabilities and pcie enables
    input  wire qmtc_pkg::qmtc_caps_s          caps,
    // queue control
    input  wire logic                          enable_req,
    input  wire logic                          disable_req,
    output logic                               queue_enabled,
    output logic                               enable_err,
    output logic [qmtc_pkg::QMTC_ERR_W-1:0]    enable_err_code,
    // descriptor input
    input  wire logic                          desc_valid,
    input  wire logic                          desc_sub_priv,
    input  wire logic [qmtc_pkg::QMTC_ID_W-1:0] desc_sub_pasid,
    input  wire logic                          desc_fault_flag,
    // descriptor output
    output logic                               out_valid,
    output qmtc_pkg::qmtc_desc_s               out_desc,
    output logic [qmtc_pkg::QMTC_PRIO_W-1:0]   out_priority,
    // page fault handling
    input  wire logic                          fault_in,
    input  wire logic                          fault_desc_flag,
    output logic                               fault_block,
    output logic                               fault_stop
);
    import qmtc_pkg::*;

    // ---------------------------------------------------------------
    // storage and state
    // ---------------------------------------------------------------
    logic [31:0]             cfg_r;
    qmtc_state_e             state_r;
    logic                    err_r;
    logic [QMTC_ERR_W-1:0]   err_code_r;
    logic                    out_valid_r;
    qmtc_desc_s              out_desc_r;
    logic [QMTC_PRIO_W-1:0]  out_prio_r;
    logic                    fault_block_r;
    logic                    fault_stop_r;
    logic [31:0]             wr_mask;
    logic [QMTC_ERR_W-1:0]   chk_err;
    logic                    wr_open;

    // decoded fields
    logic                    ded;
    logic                    iden;
    logic                    id_used;
    logic                    fbe_eff;
    qmtc_desc_s              desc_nxt;

    assign wr_open = (state_r == QMTC_ST_DISABLED);

    // ---------------------------------------------------------------
    // write mask: byte lanes, reserved bits, hardwired fields
    // ---------------------------------------------------------------
    // byte enables let software use 1-, 2- or 4-byte sub-writes
    genvar gb;
    generate
        for (gb = 0; gb < QMTC_BYTES; gb++) begin : g_lane
            assign wr_mask[gb*8 +: 8] = {8{cfg_be[gb]}};
        end
    endgenerate

    // unsupported page-request and translation-service disables are forced to
    // zero at write time so that a read of those bits returns what the hardware acts on
    function automatic logic [31:0] hardwire(input logic [31:0] w,
                                             input qmtc_caps_s c);
        logic [31:0] v;
        v = w & QMTC_WORD_MASK;
        if (!c.prs_support) begin
            v[QMTC_PRS_DIS_BIT] = 1'b0;
        end
        if (!c.ats_support) begin
            v[QMTC_ATS_DIS_BIT] = 1'b0;
        end
        return v;
    endfunction

    // word update, dropped entirely while the queue is enabled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_r <= QMTC_WORD_RESET;
        end else if (cfg_wr_en && wr_open) begin
            cfg_r <= hardwire((cfg_r & ~wr_mask) | (cfg_wdata & wr_mask),
                              caps);
        end
    end

    assign cfg_rdata = cfg_r;

    // ---------------------------------------------------------------
    // field decode
    // ---------------------------------------------------------------
    assign ded     = (cfg_r[QMTC_MODE_BIT] == QMTC_MODE_DEDICATED);
    assign iden    = cfg_r[QMTC_IDEN_BIT];
    assign id_used = ded && iden;
    // reserved without support or without page request enable
    assign fbe_eff = cfg_r[QMTC_FBE_BIT] && caps.fault_block_support
                     && caps.prs_enable;

    // ---------------------------------------------------------------
    // queue enable and consistency checking
    // ---------------------------------------------------------------
    qmtc_checker u_checker (
        .cfg_word (cfg_r),
        .caps     (caps),
        .err      (chk_err)
    );

    // a failed check leaves the queue disabled and latches the cause
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= QMTC_ST_DISABLED;
            err_r      <= 1'b0;
            err_code_r <= '0;
        end else begin
            case (state_r)
                QMTC_ST_DISABLED: begin
                    if (enable_req) begin
                        err_code_r <= chk_err;
                        err_r      <= |chk_err;
                        if (chk_err == '0) begin
                            state_r <= QMTC_ST_ENABLED;
                        end
                    end
                end
                QMTC_ST_ENABLED: begin
                    if (disable_req) begin
                        state_r <= QMTC_ST_DISABLED;
                    end
                end
                default: begin
                    state_r <= QMTC_ST_DISABLED;
                end
            endcase
        end
    end

    assign queue_enabled   = (state_r == QMTC_ST_ENABLED);
    assign enable_err      = err_r;
    assign enable_err_code = err_code_r;

    // ---------------------------------------------------------------
    // descriptor attribute stamping
    // ---------------------------------------------------------------
    // shared queues take identity from the submission itself
    always_comb begin
        desc_nxt = '0;
        if (id_used) begin
            desc_nxt.priv  = cfg_r[QMTC_PRIV_BIT];
            desc_nxt.pasid = cfg_r[QMTC_ID_HI:QMTC_ID_LO];
        end else if (!ded) begin
            desc_nxt.priv  = desc_sub_priv;
            desc_nxt.pasid = desc_sub_pasid;
        end
        desc_nxt.pasid_valid    = iden;
        desc_nxt.use_ats        = caps.ats_enable
                                  && !cfg_r[QMTC_ATS_DIS_BIT];
        desc_nxt.use_prs        = caps.prs_enable
                                  && !cfg_r[QMTC_PRS_DIS_BIT];
        // flag is reserved when blocking is off, so it is masked
        desc_nxt.block_on_fault = desc_nxt.use_prs && fbe_eff
                                  && desc_fault_flag;
    end

    // descriptors are only accepted while the queue is enabled
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out_valid_r <= 1'b0;
            out_desc_r  <= '0;
            out_prio_r  <= '0;
        end else begin
            out_valid_r <= desc_valid && queue_enabled;
            if (desc_valid && queue_enabled) begin
                out_desc_r <= desc_nxt;
                out_prio_r <= caps.priority_support
                    ? cfg_r[QMTC_PRIO_HI:QMTC_PRIO_LO] : '0;
            end
        end
    end

    assign out_valid    = out_valid_r;
    assign out_desc     = out_desc_r;
    assign out_priority = out_prio_r;

    // ---------------------------------------------------------------
    // page fault disposition
    // ---------------------------------------------------------------
    // block only if the queue allows it and the descriptor asks for it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fault_block_r <= 1'b0;
            fault_stop_r  <= 1'b0;
        end else begin
            fault_block_r <= fault_in && fbe_eff
                             && fault_desc_flag;
            fault_stop_r  <= fault_in
                             && !(fbe_eff && fault_desc_flag);
        end
    end

    assign fault_block = fault_block_r;
    assign fault_stop  = fault_stop_r;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_write_lock: assert property (
        queue_enabled && cfg_wr_en |=> $stable(cfg_rdata))
        else $error("config word changed while queue enabled");

    a_ded_priv: assert property (
        desc_valid && queue_enabled && ded && iden
        |=> out_valid && out_desc.priv == $past(cfg_r[QMTC_PRIV_BIT]))
        else $error("dedicated privilege not applied");

    a_shared_ident: assert property (
        desc_valid && queue_enabled && !ded
        |=> out_desc.pasid == $past(desc_sub_pasid))
        else $error("shared queue used stored identifier");

    a_ident_tag: assert property (
        out_valid |-> out_desc.pasid_valid == cfg_r[QMTC_IDEN_BIT])
        else $error("identifier tag disagrees with enable");

    a_prs_off: assert property (
        out_valid && cfg_r[QMTC_PRS_DIS_BIT]
        |-> !out_desc.use_prs && !out_desc.block_on_fault)
        else $error("page request used while disabled");

    a_ats_off: assert property (
        out_valid |-> out_desc.use_ats ==
            ($past(caps.ats_enable) && !cfg_r[QMTC_ATS_DIS_BIT]))
        else $error("translation service use wrong");

    a_prio_gate: assert property (
        desc_valid && queue_enabled && !caps.priority_support
        |=> out_priority == '0)
        else $error("priority passed without support");

    a_fault_stop: assert property (
        fault_in && !fbe_eff |=> fault_stop && !fault_block)
        else $error("fault not stopped with blocking off");

    a_enable_chk: assert property (
        !queue_enabled && enable_req && chk_err != '0
        |=> !queue_enabled && enable_err
            && enable_err_code == $past(chk_err))
        else $error("inconsistent config was enabled");

    a_ats_hardwire: assert property (
        cfg_wr_en && !queue_enabled && !caps.ats_support
        |=> !cfg_rdata[QMTC_ATS_DIS_BIT])
        else $error("translation disable not hardwired");

    a_fbe_masked: assert property (
        fault_in && !caps.fault_block_support |=> !fault_block)
        else $error("fault blocking used without support");

    a_prs_follow: assert property (
        out_valid && !cfg_r[QMTC_PRS_DIS_BIT]
        |-> out_desc.use_prs == $past(caps.prs_enable))
        else $error("page request use does not follow enable");

    c_enable_ok: cover property (
        !queue_enabled && enable_req && chk_err == '0 ##1 queue_enabled);
    c_ded_desc: cover property (
        desc_valid && queue_enabled && id_used ##1 out_valid);
    c_fault_blk: cover property (fault_in && fbe_eff && fault_desc_flag);
    c_lock_drop: cover property (queue_enabled && cfg_wr_en);
    c_shared_desc: cover property (
        desc_valid && queue_enabled && !ded ##1 out_valid);

endmodule // qmtc_top

// >>> verification/qmtc_tb.sv
`timescale 1ns/1ps

module testbench;
    import qmtc_pkg::*;

    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic                   mclk;
    logic                   rst_b;
    logic                   cfg_wr_en;
    logic [QMTC_BYTES-1:0]  cfg_be;
    logic [31:0]            cfg_wdata;
    logic [31:0]            cfg_rdata;
    qmtc_caps_s             caps;
    logic                   enable_req;
    logic                   disable_req;
    logic                   queue_enabled;
    logic                   enable_err;
    logic [QMTC_ERR_W-1:0]  enable_err_code;
    logic                   desc_valid;
    logic                   desc_sub_priv;
    logic [QMTC_ID_W-1:0]   desc_sub_pasid;
    logic                   desc_fault_flag;
    logic                   out_valid;
    qmtc_desc_s             out_desc;
    logic [QMTC_PRIO_W-1:0] out_priority;
    logic                   fault_in;
    logic                   fault_desc_flag;
    logic                   fault_block;
    logic                   fault_stop;
    integer                 seed;
    integer                 fails;
    integer                 n_tests;
    logic [31:0]            mdl;     // expected stored word
    logic [31:0]            r;
    logic [31:0]            g;
    logic [7:0]             st;      // queue state, error flag and code

    // state, error flag and code seen as one byte
    assign st = {queue_enabled, enable_err, enable_err_code};

    qmtc_top i_qmtc_top (
        .mclk(mclk), .rst_b(rst_b), .cfg_wr_en(cfg_wr_en), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .caps(caps),
        .enable_req(enable_req), .disable_req(disable_req),
        .queue_enabled(queue_enabled), .enable_err(enable_err),
        .enable_err_code(enable_err_code), .desc_valid(desc_valid),
        .desc_sub_priv(desc_sub_priv), .desc_sub_pasid(desc_sub_pasid),
        .desc_fault_flag(desc_fault_flag), .out_valid(out_valid),
        .out_desc(out_desc), .out_priority(out_priority),
        .fault_in(fault_in), .fault_desc_flag(fault_desc_flag),
        .fault_block(fault_block), .fault_stop(fault_stop)
    );

    // ---------------------------------------------------------------
    // expectation functions
    // ---------------------------------------------------------------
    // caps only change right before a full write, so forcing the
    // hardwired bits over the whole merged word is unambiguous
    function automatic logic [31:0] f_write(logic [31:0] old, logic [31:0] w,
                                            logic [3:0] be, qmtc_caps_s c);
        logic [31:0] n;
        n = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) n[8*i +: 8] = w[8*i +: 8];
        end
        n = n & QMTC_WORD_MASK;
        if (!c.prs_support) n[QMTC_PRS_DIS_BIT] = 1'b0;
        if (!c.ats_support) n[QMTC_ATS_DIS_BIT] = 1'b0;
        return n;
    endfunction

    function automatic logic [5:0] f_err(logic [31:0] w, qmtc_caps_s c);
        logic [5:0] e;
        e[0] = w[0] & w[28] & w[29] & !c.priv_mode_enable;
        e[1] = w[28] & !c.pasid_enable;
        e[2] = !w[0] & !w[28];
        e[3] = (w[7:4] == 4'h0) & c.priority_support;
        e[4] = w[3] & w[1];
        e[5] = w[3] & !c.event_log_enable;
        return e;
    endfunction

    function automatic logic f_fbe(logic [31:0] w, qmtc_caps_s c);
        return w[1] & c.fault_block_support & c.prs_enable;
    endfunction

    function automatic qmtc_desc_s f_desc(logic [31:0] w, qmtc_caps_s c,
                                          logic sp, logic [19:0] sa, logic fl);
        qmtc_desc_s d;
        d.priv  = w[0] ? (w[28] & w[29]) : sp;
        d.pasid = w[0] ? (w[28] ? w[27:8] : 20'h0) : sa;
        d.pasid_valid    = w[28];
        d.use_ats        = c.ats_enable & !w[2];
        d.use_prs        = c.prs_enable & !w[3];
        d.block_on_fault = d.use_prs & f_fbe(w, c) & fl;
        return d;
    endfunction

    // ---------------------------------------------------------------
    // compare and drive tasks
    // ---------------------------------------------------------------
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_desc(input qmtc_desc_s got, input qmtc_desc_s exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one write pulse; the model only takes it while the queue is off
    task automatic wr(input logic [31:0] w, input logic [3:0] be);
        logic qe;
        qe        = queue_enabled;
        cfg_wr_en = 1'b1;
        cfg_wdata = w;
        cfg_be    = be;
        tick();
        cfg_wr_en = 1'b0;
        if (qe === 1'b0) mdl = f_write(mdl, w, be, caps);
        cmp_word(cfg_rdata, mdl);
        // one idle edge so a following write never re-raises the strobe
        tick();
    endtask

    task automatic try_enable();
        logic [5:0] e;
        e          = f_err(mdl, caps);
        enable_req = 1'b1;
        tick();
        enable_req = 1'b0;
        cmp_flags(st, {e == 6'h0, e != 6'h0, e});
    endtask

    task automatic do_disable();
        disable_req = 1'b1;
        tick();
        disable_req = 1'b0;
        cmp_flags({7'h0, queue_enabled}, 8'h00);
    endtask

    // back-to-back descriptors and faults, checked one cycle later
    task automatic run_desc(input int n, input logic en);
        qmtc_desc_s e;
        logic [1:0] ef;
        logic       ev;
        logic [3:0] ep;
        for (int i = 0; i <= n; i++) begin
            r               = $random(seed);
            ev              = (i < n);
            desc_valid      = ev;
            desc_sub_priv   = r[0];
            desc_fault_flag = r[1];
            desc_sub_pasid  = r[31:12];
            fault_in        = ev & r[2];
            fault_desc_flag = r[3];
            e  = f_desc(mdl, caps, r[0], r[31:12], r[1]);
            ef = !fault_in ? 2'b00 : (f_fbe(mdl, caps) & r[3]) ? 2'b10 : 2'b01;
            ep = caps.priority_support ? mdl[7:4] : 4'h0;
            tick();
            cmp_flags({7'h0, out_valid}, {7'h0, ev & en});
            cmp_flags({6'h0, fault_block, fault_stop}, {6'h0, ef});
            if (ev && en) begin
                cmp_desc(out_desc, e);
                cmp_flags({4'h0, out_priority}, {4'h0, ep});
            end
        end
        desc_valid = 1'b0;
        fault_in   = 1'b0;
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // clock, watchdog and main sequence
    // ---------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // cuts a hang short; counts as a mismatch
    initial begin
        #2500000;
        fails++;
        test_done();
    end

    initial begin
        seed = 32'h89113cfd;
        fails = 0;
        n_tests = 0;
        rst_b = 1'b0;
        {cfg_wr_en, enable_req, disable_req, desc_valid, fault_in} = '0;
        {desc_sub_priv, desc_fault_flag, fault_desc_flag} = '0;
        cfg_be = '0;
        cfg_wdata = '0;
        desc_sub_pasid = '0;
        caps = '1;
        mdl = QMTC_WORD_RESET;
        repeat (16) @(posedge mclk);
        #1;
        cmp_word(cfg_rdata, QMTC_WORD_RESET);
        cmp_flags(st, 8'h00);
        rst_b = 1'b1;
        tick();
        $display("reset test done");
        // corner cases: stray control, reserved bits, empty lanes
        do_disable();
        run_desc(2, 1'b0);
        wr(32'hffff_ffff, 4'hf);
        wr(32'h0000_0000, 4'h0);
        $display("corner test done");
        for (int k = 0; k < 60; k++) begin
            r = $random(seed);
            caps = r[8:0];
            wr($random(seed), 4'hf);
            r = $random(seed);
            wr($random(seed), r[3:0]);
            try_enable();
            if (queue_enabled !== 1'b1) begin
                g = $random(seed);
                g[28] = caps.pasid_enable;
                if (!caps.pasid_enable) g[0] = 1'b1;
                if (!caps.priv_mode_enable) g[29] = 1'b0;
                if (g[7:4] == 4'h0) g[4] = 1'b1;
                if (!caps.event_log_enable) g[3] = 1'b0;
                if (g[3]) g[1] = 1'b0;
                wr(g, 4'hf);
                try_enable();
            end
            wr($random(seed), 4'hf);
            enable_req = 1'b1;
            tick();
            enable_req = 1'b0;
            cmp_flags(st, 8'h80);
            run_desc(4, 1'b1);
            do_disable();
        end
        $display("random test done");
        // second reset in mid-run clears the word and the queue
        rst_b = 1'b0;
        tick();
        cmp_word(cfg_rdata, QMTC_WORD_RESET);
        cmp_flags({7'h0, queue_enabled}, 8'h00);
        rst_b = 1'b1;
        // a write at the first edge after release must land
        mdl = QMTC_WORD_RESET;
        wr(32'h1234_5601, 4'h3);
        $display("second reset test done");
        test_done();
    end

endmodule // testbench
